//--- rtl/system_supervisor.sv
// System supervisor: watchdog, low-voltage reset gating, external reset pin, pin wake-up
// and the clock-switch hazard. Assumes all inputs are synchronous to clk_i.
`timescale 1ns/1ps
module system_supervisor
  import supervisor_pkg::*;
#(
  parameter int NPINS = 8,
  parameter int WDT_SEL0 = WDT_TICKS_SEL0,
  parameter int WDT_SEL1 = WDT_TICKS_SEL1,
  parameter int WDT_SEL2 = WDT_TICKS_SEL2,
  parameter int WDT_SEL3 = WDT_TICKS_SEL3,
  parameter int NORMAL_WAKE = NORMAL_WAKE_TICKS
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register writes from the CPU
  input wire logic misc_wr_i,
  input wire logic [7:0] misc_wdata_i,
  input wire logic clock_mode_wr_i,
  input wire logic [7:0] clock_mode_wdata_i,
  input wire logic wake_en_wr_i,
  input wire logic [NPINS-1:0] wake_en_wdata_i,
  // CPU state and instructions
  input wire logic wdt_clear_i,
  input wire logic cpu_halt_i,
  input wire logic sys_halt_i,
  input wire logic fast_wake_i,
  // Oscillator and power
  input wire logic lrc_tick_i,
  input wire logic power_on_done_i,
  input wire logic vdd_low_i,
  // Pins
  input wire logic pin_a5_i,
  input wire logic pin_a5_is_input_i,
  input wire logic [NPINS-1:0] pin_in_i,
  input wire logic [NPINS-1:0] pin_dir_input_i,
  // Register views
  output logic [7:0] misc_o,
  output logic [7:0] clock_mode_control_o,
  output logic [NPINS-1:0] port_input_wake_enable_o,
  // Status and resets
  output logic chip_reset_o,
  output logic wdt_reset_o,
  output logic low_voltage_reset_o,
  output logic external_reset_o,
  output logic resume_o,
  output logic stall_o
);

  logic [7:0] misc_nxt;
  logic [7:0] clock_mode_control_nxt;
  logic [NPINS-1:0] wake_en_nxt;
  logic stall_nxt;
  logic [NPINS-1:0] pins_prev_r;
  logic lvr_nxt;
  logic ext_nxt;
  logic chip_nxt;
  wake_state_e wake_state_r;
  wake_state_e wake_state_nxt;
  logic resume_nxt;
  logic wdt_tick;
  logic wdt_done;
  logic [WDT_W-1:0] wdt_last;
  logic wake_event;
  logic wake_done;
  logic [6:0] wake_last;
  logic [2:0] old_src;
  logic old_osc_off;

  // Registers and the clock-switch hazard.
  always_comb
  begin
    misc_nxt = misc_o;
    clock_mode_control_nxt = clock_mode_control_o;
    wake_en_nxt = port_input_wake_enable_o;
    stall_nxt = stall_o;
    old_src = clock_mode_control_o[CLOCK_MODE_CONTROL_SRC_LSB +: 3];
    old_osc_off = 1'b0;
    if (misc_wr_i)
    begin
      misc_nxt = misc_wdata_i;
    end
    if (wake_en_wr_i)
    begin
      wake_en_nxt = wake_en_wdata_i;
    end
    if (clock_mode_wr_i)
    begin
      clock_mode_control_nxt = clock_mode_wdata_i;
      if (old_src == SRC_LRC)
      begin
        old_osc_off = !clock_mode_wdata_i[CLOCK_MODE_CONTROL_LRC_EN_BIT];
      end
      else
      begin
        old_osc_off = !clock_mode_wdata_i[CLOCK_MODE_CONTROL_HRC_EN_BIT];
      end
      if (old_osc_off && (clock_mode_wdata_i[CLOCK_MODE_CONTROL_SRC_LSB +: 3] != old_src))
      begin
        stall_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      misc_o <= MISC_RESET;
      clock_mode_control_o <= CLOCK_MODE_CONTROL_RESET;
      port_input_wake_enable_o <= '0;
      stall_o <= 1'b0;
    end
    else
    begin
      misc_o <= misc_nxt;
      clock_mode_control_o <= clock_mode_control_nxt;
      port_input_wake_enable_o <= wake_en_nxt;
      stall_o <= stall_nxt;
    end
  end

  always_comb
  begin
    unique case (misc_o[MISC_WDT_SEL_LSB +: 2])
      2'b00: wdt_last = WDT_W'(WDT_SEL0 - 1);
      2'b01: wdt_last = WDT_W'(WDT_SEL1 - 1);
      2'b10: wdt_last = WDT_W'(WDT_SEL2 - 1);
      2'b11: wdt_last = WDT_W'(WDT_SEL3 - 1);
    endcase
  end

  assign wdt_tick = lrc_tick_i && clock_mode_control_o[CLOCK_MODE_CONTROL_WDT_EN_BIT]
                    && clock_mode_control_o[CLOCK_MODE_CONTROL_LRC_EN_BIT];

  period_counter #(.W(WDT_W)) wdt_counter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(wdt_clear_i),
    .tick_i(wdt_tick),
    .last_i(wdt_last),
    .done_o(wdt_done)
  );

  // Reset sources; every reset output is a registered level or pulse.
  always_comb
  begin
    lvr_nxt = vdd_low_i && power_on_done_i && !misc_o[MISC_LVR_OFF_BIT]
              && !cpu_halt_i && !sys_halt_i;
    ext_nxt = clock_mode_control_o[CLOCK_MODE_CONTROL_RST_PIN_BIT] && pin_a5_is_input_i && !pin_a5_i;
    chip_nxt = wdt_done || lvr_nxt || ext_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      low_voltage_reset_o <= 1'b0;
      external_reset_o <= 1'b0;
      wdt_reset_o <= 1'b0;
      chip_reset_o <= 1'b0;
    end
    else
    begin
      low_voltage_reset_o <= lvr_nxt;
      external_reset_o <= ext_nxt;
      wdt_reset_o <= wdt_done;
      chip_reset_o <= chip_nxt;
    end
  end

  // enabled input pins wake the device
  assign wake_event = (cpu_halt_i || sys_halt_i)
                      && |((pin_in_i ^ pins_prev_r) & port_input_wake_enable_o & pin_dir_input_i);

  assign wake_last = fast_wake_i ? 7'(FAST_WAKE_TICKS - 1) : 7'(NORMAL_WAKE - 1);

  period_counter #(.W(7)) wake_counter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(wake_state_r == WAKE_IDLE),
    .tick_i(lrc_tick_i && clock_mode_control_o[CLOCK_MODE_CONTROL_LRC_EN_BIT]),
    .last_i(wake_last),
    .done_o(wake_done)
  );

  always_comb
  begin
    wake_state_nxt = wake_state_r;
    resume_nxt = 1'b0;
    unique case (wake_state_r)
      WAKE_IDLE:
      begin
        if (wake_event)
        begin
          wake_state_nxt = WAKE_WAIT;
        end
      end
      WAKE_WAIT:
      begin
        if (wake_done)
        begin
          wake_state_nxt = WAKE_IDLE;
          resume_nxt = 1'b1;
        end
      end
      default:
      begin
        wake_state_nxt = WAKE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wake_state_r <= WAKE_IDLE;
      resume_o <= 1'b0;
      pins_prev_r <= '0;
    end
    else
    begin
      wake_state_r <= wake_state_nxt;
      resume_o <= resume_nxt;
      pins_prev_r <= pin_in_i;
    end
  end

  // Helper counters that only the assertions read.
  logic [WDT_W:0] wdt_seen_r;
  logic [7:0] wake_seen_r;

  always_ff @(posedge clk_i)
  begin
    if (reset_i || wdt_clear_i || wdt_done)
    begin
      wdt_seen_r <= '0;
    end
    else if (wdt_tick)
    begin
      wdt_seen_r <= wdt_seen_r + 1'b1;
    end
    if (reset_i || wake_state_r == WAKE_IDLE)
    begin
      wake_seen_r <= '0;
    end
    else if (lrc_tick_i && clock_mode_control_o[CLOCK_MODE_CONTROL_LRC_EN_BIT])
    begin
      wake_seen_r <= wake_seen_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  wdt_period_a: assert property (wdt_done |-> wdt_seen_r == ({1'b0, $past(wdt_last)} + 1'b1))
    else $error("Watchdog timeout after wrong tick count.");
  wdt_default_a: assert property ($fell(reset_i) |-> clock_mode_control_o[CLOCK_MODE_CONTROL_WDT_EN_BIT])
    else $error("Watchdog not enabled after reset.");
  wdt_lrc_gate_a: assert property (!clock_mode_control_o[CLOCK_MODE_CONTROL_LRC_EN_BIT] && !wdt_clear_i
                                   && !wdt_done |=> $stable(wdt_seen_r))
    else $error("Watchdog advanced with oscillator off.");
  lvr_disable_a: assert property (misc_o[MISC_LVR_OFF_BIT] |=> !low_voltage_reset_o)
    else $error("Low-voltage reset fired while disabled.");
  lvr_halt_a: assert property ((cpu_halt_i || sys_halt_i) |=> !low_voltage_reset_o)
    else $error("Low-voltage reset fired in halt.");
  lvr_power_on_a: assert property (!power_on_done_i |=> !low_voltage_reset_o)
    else $error("Low-voltage reset fired before power-on done.");
  fast_wake_a: assert property (resume_o && $past(fast_wake_i)
                                |-> $past(wake_seen_r) == 8'(FAST_WAKE_TICKS))
    else $error("Fast wake-up not 45 oscillator periods.");
  reset_pin_a: assert property (clock_mode_control_o[CLOCK_MODE_CONTROL_RST_PIN_BIT] && pin_a5_is_input_i
                                && !pin_a5_i |=> external_reset_o && chip_reset_o)
    else $error("Reset pin low did not reset the chip.");
  clock_hang_a: assert property (stall_o |=> stall_o [*8])
    else $error("Stall released without reset.");
  lrc_disable_a: assert property (clock_mode_wr_i && !clock_mode_wdata_i[CLOCK_MODE_CONTROL_LRC_EN_BIT]
                                  |=> !clock_mode_control_o[CLOCK_MODE_CONTROL_LRC_EN_BIT])
    else $error("Oscillator not disabled by write.");
  wake_enable_a: assert property ($rose(wake_state_r == WAKE_WAIT)
                                  |-> $past(|(port_input_wake_enable_o & pin_dir_input_i)))
    else $error("Wake-up from a pin not enabled.");
  wdt_restart_a: assert property (wdt_clear_i |=> !wdt_done ##1 (wdt_seen_r <= 1))
    else $error("Watchdog clear did not restart count.");
  wdt_reset_a: assert property (wdt_done |=> wdt_reset_o && chip_reset_o)
    else $error("Watchdog timeout without chip reset.");

  wdt_timeout_c: cover property (wdt_done ##1 chip_reset_o);
  fast_resume_c: cover property (fast_wake_i && wake_event ##[1:1000] resume_o);
  clock_hang_c: cover property ($rose(stall_o));
  lvr_fire_c: cover property ($rose(low_voltage_reset_o));

endmodule

//--- rtl/supervisor_pkg.sv
// Constants for the system supervisor: watchdog, low-voltage reset, reset pin and wake-up.
// Assumes a single 25 MHz clock and a one-cycle tick per low-speed RC oscillator period.
// Function
// - The two low misc bits pick a watchdog timeout of 8192, 16384, 65536 or 262144 RC periods.
// - The watchdog is enabled straight out of reset with no software setup.
// - The watchdog does not count while the low-speed RC oscillator is off.
// - Writing 1 to misc bit 2 turns the low-voltage reset off.
// - The low-voltage reset never fires during CPU halt or full system halt.
// - The low-voltage reset threshold only acts after power-on has completed.
// - With fast wake-up selected, execution resumes 45 RC periods after the wake event.
// - With pin A5 an input and clock mode bit 0 set, a low on the pin resets the chip.
// - Clearing clock mode bit 2 turns the low-speed RC oscillator off.
// - An input pin whose wake-enable bit is 1 may wake the device.
// - The watchdog clear instruction restarts the watchdog count from zero.
package supervisor_pkg;

  // Misc control register layout.
  localparam int MISC_WDT_SEL_LSB = 0;
  localparam int MISC_LVR_OFF_BIT = 2;
  localparam logic [7:0] MISC_RESET = 8'h00;

  // Clock mode control register layout.
  localparam int CLOCK_MODE_CONTROL_RST_PIN_BIT = 0;
  localparam int CLOCK_MODE_CONTROL_WDT_EN_BIT = 1;
  localparam int CLOCK_MODE_CONTROL_LRC_EN_BIT = 2;
  localparam int CLOCK_MODE_CONTROL_HRC_EN_BIT = 4;
  localparam int CLOCK_MODE_CONTROL_SRC_LSB = 5;
  localparam logic [7:0] CLOCK_MODE_CONTROL_RESET = 8'h16;

  // Clock source codes in the source field.
  localparam logic [2:0] SRC_HRC = 3'h0;
  localparam logic [2:0] SRC_LRC = 3'h1;

  // Watchdog and wake-up counts in low-speed RC periods.
  localparam int WDT_W = 18;
  localparam int WDT_TICKS_SEL0 = 8192;
  localparam int WDT_TICKS_SEL1 = 16384;
  localparam int WDT_TICKS_SEL2 = 65536;
  localparam int WDT_TICKS_SEL3 = 262144;
  localparam int FAST_WAKE_TICKS = 45;
  localparam int NORMAL_WAKE_TICKS = 1024;

  typedef enum logic [1:0] {
    WAKE_IDLE = 2'b01,
    WAKE_WAIT = 2'b10
  } wake_state_e;

endpackage

//--- rtl/period_counter.sv
// Counts qualified ticks and pulses once when the count passes a programmable last value.
// Assumes ticks are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
module period_counter
  import supervisor_pkg::*;
#(
  parameter int W = 18
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [W-1:0] last_i,
  // Result
  output logic done_o
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic done_nxt;

  // Clear wins over a tick in the same cycle, so a restart is never lost.
  always_comb
  begin
    count_nxt = count_r;
    done_nxt = 1'b0;
    if (clear_i)
    begin
      count_nxt = '0;
    end
    else if (tick_i)
    begin
      if (count_r == last_i)
      begin
        count_nxt = '0;
        done_nxt = 1'b1;
      end
      else
      begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_r <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      done_o <= done_nxt;
    end
  end

endmodule

//--- testbench/tb_system_supervisor.sv
// Self-checking bench for the system supervisor: registers, watchdog, resets, wake, stall.
// Assumes short watchdog and wake counts handed to the supervisor as parameters.
`timescale 1ns/1ps
module tb_system_supervisor;
  import supervisor_pkg::*;
  localparam int SEL [4] = '{16, 32, 64, 128};
  typedef struct packed {
    logic vdd, pod, off, ch, sh, pen, a5in, a5, low_voltage_reset, ext;
  } case_s;
  logic clk_i, reset_i, misc_wr_i, clock_mode_wr_i, wake_en_wr_i;
  logic [7:0] misc_wdata_i, clock_mode_wdata_i, wake_en_wdata_i, pin_in_i, pin_dir_input_i;
  logic [7:0] misc_o, clock_mode_control_o, port_input_wake_enable_o;
  logic wdt_clear_i, cpu_halt_i, sys_halt_i, fast_wake_i, lrc_tick_i, power_on_done_i;
  logic vdd_low_i, pin_a5_i, pin_a5_is_input_i;
  logic chip_reset_o, wdt_reset_o, low_voltage_reset_o, external_reset_o, resume_o, stall_o;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int wdt_cnt = 0;
  int chip_cnt = 0;
  int res_cnt = 0;
  case_s rows [9] = '{
    10'b11000_011_10, 10'b10000_011_00, 10'b11100_011_00, 10'b11010_011_00,
    10'b11001_011_00, 10'b01000_110_01, 10'b01000_010_00, 10'b01000_100_00,
    10'b01000_111_00};

  system_supervisor #(.WDT_SEL0(16), .WDT_SEL1(32), .WDT_SEL2(64),
    .WDT_SEL3(128), .NORMAL_WAKE(8)) i_system_supervisor (
    .clk_i(clk_i), .reset_i(reset_i), .misc_wr_i(misc_wr_i), .misc_wdata_i(misc_wdata_i),
    .clock_mode_wr_i(clock_mode_wr_i), .clock_mode_wdata_i(clock_mode_wdata_i),
    .wake_en_wr_i(wake_en_wr_i), .wake_en_wdata_i(wake_en_wdata_i),
    .wdt_clear_i(wdt_clear_i), .cpu_halt_i(cpu_halt_i), .sys_halt_i(sys_halt_i),
    .fast_wake_i(fast_wake_i), .lrc_tick_i(lrc_tick_i), .power_on_done_i(power_on_done_i),
    .vdd_low_i(vdd_low_i), .pin_a5_i(pin_a5_i), .pin_a5_is_input_i(pin_a5_is_input_i),
    .pin_in_i(pin_in_i), .pin_dir_input_i(pin_dir_input_i), .misc_o(misc_o),
    .clock_mode_control_o(clock_mode_control_o),
    .port_input_wake_enable_o(port_input_wake_enable_o), .chip_reset_o(chip_reset_o),
    .wdt_reset_o(wdt_reset_o), .low_voltage_reset_o(low_voltage_reset_o),
    .external_reset_o(external_reset_o), .resume_o(resume_o), .stall_o(stall_o));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Pulse counters and the hang limit.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (wdt_reset_o === 1'b1) wdt_cnt <= wdt_cnt + 1;
    if (chip_reset_o === 1'b1) chip_cnt <= chip_cnt + 1;
    if (resume_o === 1'b1) res_cnt <= res_cnt + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i) lrc_tick_i <= 1'b1;
      @(posedge clk_i) lrc_tick_i <= 1'b0;
    end
  endtask

  // Register 0 is misc, 1 is clock mode, 2 is wake enable.
  task automatic wr(input int r, input logic [7:0] v);
    @(posedge clk_i);
    misc_wr_i <= (r == 0);
    clock_mode_wr_i <= (r == 1);
    wake_en_wr_i <= (r == 2);
    misc_wdata_i <= v;
    clock_mode_wdata_i <= v;
    wake_en_wdata_i <= v;
    @(posedge clk_i);
    misc_wr_i <= 1'b0;
    clock_mode_wr_i <= 1'b0;
    wake_en_wr_i <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    reset_i <= 1'b1;
    cyc(6);
    reset_i <= 1'b0;
  endtask

  // Watchdog is switched off so that only the wake path produces pulses.
  task automatic wake(input logic sh, input logic fast, input logic [7:0] en, input int k,
    input int exp);
    int r0;
    do_reset();
    wr(1, 8'h14);
    wr(2, en);
    fast_wake_i <= fast;
    cpu_halt_i <= !sh;
    sys_halt_i <= sh;
    r0 = res_cnt;
    @(posedge clk_i);
    pin_in_i[0] <= ~pin_in_i[0];
    ticks(k - 1);
    cyc(4);
    check("resume early", r0, res_cnt);
    check("wake en view", en, port_input_wake_enable_o);
    ticks(1);
    cyc(4);
    check("resume", r0 + exp, res_cnt);
    cpu_halt_i <= 1'b0;
    sys_halt_i <= 1'b0;
  endtask

  initial
  begin
    int w0;
    int c0;
    reset_i = 1'b1;
    {misc_wr_i, clock_mode_wr_i, wake_en_wr_i, wdt_clear_i} = '0;
    {cpu_halt_i, sys_halt_i, fast_wake_i, lrc_tick_i, vdd_low_i, pin_a5_is_input_i} = '0;
    {misc_wdata_i, clock_mode_wdata_i, wake_en_wdata_i, pin_in_i} = '0;
    pin_dir_input_i = 8'hFF;
    power_on_done_i = 1'b1;
    pin_a5_i = 1'b1;
    do_reset();
    cyc(1);
    check("misc reset", MISC_RESET, misc_o);
    check("clock mode reset", CLOCK_MODE_CONTROL_RESET, clock_mode_control_o);
    check("wake en reset", 8'h00, port_input_wake_enable_o);
    check("flags reset", 6'h00, {chip_reset_o, wdt_reset_o, low_voltage_reset_o,
      external_reset_o, resume_o, stall_o});
    foreach (rows[i])
    begin
      wr(0, {5'h00, rows[i].off, 2'b00});
      wr(1, {CLOCK_MODE_CONTROL_RESET[7:1], rows[i].pen});
      {vdd_low_i, power_on_done_i, cpu_halt_i, sys_halt_i} <= {rows[i].vdd, rows[i].pod,
        rows[i].ch, rows[i].sh};
      {pin_a5_is_input_i, pin_a5_i} <= {rows[i].a5in, rows[i].a5};
      cyc(3);
      check("low voltage reset", rows[i].low_voltage_reset, low_voltage_reset_o);
      check("external reset", rows[i].ext, external_reset_o);
      check("chip reset level", rows[i].low_voltage_reset | rows[i].ext, chip_reset_o);
      check("misc view", {5'h00, rows[i].off, 2'b00}, misc_o);
    end
    {vdd_low_i, cpu_halt_i, sys_halt_i, pin_a5_i} <= 4'b0001;
    for (int s = 0; s < 4; s++)
    begin
      do_reset();
      if (s > 0) wr(0, 8'(s));
      w0 = wdt_cnt;
      c0 = chip_cnt;
      ticks(SEL[s] - 1);
      cyc(3);
      check("wdt early", w0, wdt_cnt);
      ticks(1);
      cyc(4);
      check("wdt timeout", w0 + 1, wdt_cnt);
      check("wdt chip reset", c0 + 1, chip_cnt);
    end
    do_reset();
    w0 = wdt_cnt;
    ticks(SEL[0] - 2);
    @(posedge clk_i) wdt_clear_i <= 1'b1;
    @(posedge clk_i) wdt_clear_i <= 1'b0;
    ticks(SEL[0] - 1);
    cyc(3);
    check("wdt after clear", w0, wdt_cnt);
    ticks(1);
    cyc(4);
    check("wdt after clear fire", w0 + 1, wdt_cnt);
    do_reset();
    wr(1, 8'h12);
    w0 = wdt_cnt;
    ticks(SEL[0] + 2);
    cyc(3);
    check("wdt lrc off", w0, wdt_cnt);
    do_reset();
    wr(1, 8'h36);
    wr(1, 8'h26);
    cyc(1);
    check("legal switch", 1'b0, stall_o);
    check("clock mode view", 8'h26, clock_mode_control_o);
    do_reset();
    wr(1, 8'h26);
    cyc(1);
    check("forbidden switch", 1'b1, stall_o);
    wake(1'b0, 1'b1, 8'h01, 45, 1);
    wake(1'b1, 1'b0, 8'h01, 8, 1);
    wake(1'b0, 1'b1, 8'h00, 45, 0);
    // An enabled pin that is not a digital input must not wake the device.
    pin_dir_input_i <= 8'hFE;
    wake(1'b0, 1'b1, 8'h01, 45, 0);
    end_of_test();
  end
endmodule
